// >>> pkg/tos_regs.vh
// Purpose: Offsets, field positions and reset values of the tie-off
//          override and level-control status register bank.
// Assumes: Nine-bit register words reached by a seven-bit address.
// Notes:   Definitions only; included by bare name.
`ifndef TOS_REGS_VH
`define TOS_REGS_VH

////////////////////////////////////////////////////////////////////////////
// Widths
`define TOS_AW              7
`define TOS_DW              9
`define TOS_NIN             8
`define TOS_NLAD            3

////////////////////////////////////////////////////////////////////////////
// Register addresses
`define TOS_ADDR_IN_TIEOFF  7'h4a
`define TOS_ADDR_BIAS_FORCE 7'h4b
`define TOS_ADDR_P2P        7'h4c
`define TOS_ADDR_PEAK       7'h4d
`define TOS_ADDR_AMUTE_STAT 7'h4e

////////////////////////////////////////////////////////////////////////////
// Input tie-off manual control fields
`define TOS_IN_OVR_EN_BIT   8
`define TOS_IN_FORCE_MSB    7
`define TOS_IN_FORCE_LSB    0

////////////////////////////////////////////////////////////////////////////
// Bias trim and buffer force fields (bit 7 reserved)
`define TOS_HALF_BIAS_BIT   8
`define TOS_BIAS_UP_BIT     6
`define TOS_BIAS_DN_BIT     5
`define TOS_BUF_BYPASS_BIT  4
`define TOS_BUF_GROUND_BIT  3
`define TOS_LAD_MSB         2
`define TOS_LAD_LSB         0
`define TOS_BIAS_WMASK      9'h17f

////////////////////////////////////////////////////////////////////////////
// Automute and status fields
`define TOS_AMUTE_SEL_BIT   3
`define TOS_SPK_HIGH_BIT    1
`define TOS_NGATE_BIT       0

////////////////////////////////////////////////////////////////////////////
// Reset values
`define TOS_IN_TIEOFF_RST   9'h000
`define TOS_BIAS_FORCE_RST  9'h000
`define TOS_AMUTE_SEL_RST   1'h0
`define TOS_RDATA_RST       9'h000
`define TOS_ZERO9           9'h000

`endif

// >>> design/tos_switch_mux.v
// Purpose: Per-input choice between automatic and forced tie-off switch.
// Assumes: All inputs synchronous to the core clock.
// Notes:   Combinational; the parent registers the result.
`timescale 1ns/1ps

module tos_switch_mux #(
  parameter N = 8
) (
  // Selection
  input  wire         override_en_i,
  input  wire [N-1:0] force_i,
  input  wire [N-1:0] auto_i,
  // Result
  output wire [N-1:0] closed_o
);

  ////////////////////////////////////////////////////////////////////////
  // One mux per input pin
  genvar k;
  generate
    for (k = 0; k < N; k = k + 1) begin : g_sw
      assign closed_o[k] = override_en_i ? force_i[k] : auto_i[k];
    end
  endgenerate

endmodule // tos_switch_mux

// >>> design/tos_max_sel.v
// Purpose: Pick the level-control readout from the left and right values.
// Assumes: Enables tell which channels are under level control.
// Notes:   Combinational; larger value when both channels are enabled.
`timescale 1ns/1ps

module tos_max_sel #(
  parameter W = 9
) (
  // Channel enables
  input  wire         left_en_i,
  input  wire         right_en_i,
  // Channel values
  input  wire [W-1:0] left_val_i,
  input  wire [W-1:0] right_val_i,
  // Chosen value
  output reg  [W-1:0] val_o
);

  ////////////////////////////////////////////////////////////////////////
  // Larger of two when both active, right when only right active, else left
  always @* begin
    if (left_en_i && right_en_i) begin
      val_o = (left_val_i > right_val_i) ? left_val_i : right_val_i;
    end else if (right_en_i) begin
      val_o = right_val_i;
    end else begin
      val_o = left_val_i;
    end
  end

endmodule // tos_max_sel

// >>> design/tos_regs.v
// Purpose: Tie-off override, bias trim and level-control status registers.
// Assumes: Control port gives address, write and read strobes, all on the
//          core clock; detector and level-control values are synchronous.
// Notes:   Read data is registered and valid one cycle after the strobe.
`timescale 1ns/1ps
`include "tos_regs.vh"

// Function
// - Input tie-off force bits act only while override enable is set.
// - Forced input switch is open for 0, closed for 1; eight inputs.
// - Half-bias bit set halves mix/boost bias current.
// - Bias-increase bit set raises mix/boost bias by fixed step.
// - Bias-decrease bit set lowers mix/boost bias by fixed step.
// - Bypass force bit closes buffer bypass switch while buffer is disabled.
// - Ground force bit closes buffer output ground switch while disabled.
// - Each ladder force bit closes its ground switch, else power setting.
// - Read-only peak-to-peak readout, larger channel when both controlled.
// - Read-only peak readout, larger channel when both controlled.
// - Automute select 0 watches attenuator input, 1 the serial DAC pin.
// - Read-only flag is 1 when speaker supply is at or above threshold.
// - Read-only noise gate flag is 1 below threshold, gain then frozen.
// - Gate source bit picks peak (0) or peak-to-peak (1) comparison.
module tos_regs (
  // Clock and reset
  input  wire                      clock_i,
  input  wire                      nrst_i,
  // Control port
  input  wire [`TOS_AW-1:0]        addr_i,
  input  wire [`TOS_DW-1:0]        wdata_i,
  input  wire                      wr_i,
  input  wire                      rd_i,
  output reg  [`TOS_DW-1:0]        rdata_o,
  output reg                       rvalid_o,
  // Level-control detector values
  input  wire                      alc_left_en_i,
  input  wire                      alc_right_en_i,
  input  wire [`TOS_DW-1:0]        p2p_left_i,
  input  wire [`TOS_DW-1:0]        p2p_right_i,
  input  wire [`TOS_DW-1:0]        peak_left_i,
  input  wire [`TOS_DW-1:0]        peak_right_i,
  // Noise gate configuration
  input  wire                      gate_source_select_i,
  input  wire [`TOS_DW-1:0]        gate_threshold_i,
  // Speaker supply detector
  input  wire                      speaker_supply_high_i,
  // Automatic switch controls
  input  wire [`TOS_NIN-1:0]       auto_in_tieoff_i,
  input  wire                      auto_buf_bypass_i,
  input  wire                      auto_buf_ground_i,
  input  wire                      in_buffer_disabled_i,
  input  wire [`TOS_NLAD-1:0]      pm_ladder_ground_i,
  // Switch and bias controls
  output reg  [`TOS_NIN-1:0]       in_tieoff_closed_o,
  output reg                       buf_bypass_closed_o,
  output reg                       buf_ground_closed_o,
  output reg  [`TOS_NLAD-1:0]      ladder_ground_closed_o,
  output reg                       half_bias_o,
  output reg                       bias_up_o,
  output reg                       bias_dn_o,
  // Automute and noise gate
  output reg                       automute_point_select_o,
  output reg                       noise_gate_flag_o,
  output reg                       gain_hold_o
);

  ////////////////////////////////////////////////////////////////////////
  // Stored control registers
  reg  [`TOS_DW-1:0]   input_tieoff_manual_ctrl_reg;
  reg  [`TOS_DW-1:0]   input_tieoff_manual_ctrl_next;
  reg  [`TOS_DW-1:0]   bias_trim_and_buffer_force_reg;
  reg  [`TOS_DW-1:0]   bias_trim_and_buffer_force_next;
  reg                  automute_point_select_reg;
  reg                  automute_point_select_next;

  // Sampled status
  reg                  speaker_supply_high_reg;
  reg                  noise_gate_reg;
  reg                  noise_gate_next;

  // Read path
  reg  [`TOS_DW-1:0]   rdata_next;

  // Derived values
  wire [`TOS_DW-1:0]   peak_to_peak_value;
  wire [`TOS_DW-1:0]   peak_detector_value;
  wire [`TOS_NIN-1:0]  in_tieoff_closed_next;
  wire                 input_override_enable;
  wire [`TOS_NIN-1:0]  in_force_bits;
  wire                 half_bias_select;
  wire                 bias_increase_step;
  wire                 bias_decrease_step;
  wire                 force_in_buffer_bypass;
  wire                 force_in_buffer_ground;
  wire [`TOS_NLAD-1:0] force_ladder_ground;
  wire [`TOS_DW-1:0]   gate_compare_value;
  wire [`TOS_DW-1:0]   status_word;

  // Write decode
  wire                 wr_in_tieoff;
  wire                 wr_bias_force;
  wire                 wr_amute_stat;

  ////////////////////////////////////////////////////////////////////////
  // Field extraction
  assign input_override_enable =
    input_tieoff_manual_ctrl_reg[`TOS_IN_OVR_EN_BIT];
  assign in_force_bits =
    input_tieoff_manual_ctrl_reg[`TOS_IN_FORCE_MSB:`TOS_IN_FORCE_LSB];
  assign half_bias_select =
    bias_trim_and_buffer_force_reg[`TOS_HALF_BIAS_BIT];
  assign bias_increase_step =
    bias_trim_and_buffer_force_reg[`TOS_BIAS_UP_BIT];
  assign bias_decrease_step =
    bias_trim_and_buffer_force_reg[`TOS_BIAS_DN_BIT];
  assign force_in_buffer_bypass =
    bias_trim_and_buffer_force_reg[`TOS_BUF_BYPASS_BIT];
  assign force_in_buffer_ground =
    bias_trim_and_buffer_force_reg[`TOS_BUF_GROUND_BIT];
  assign force_ladder_ground =
    bias_trim_and_buffer_force_reg[`TOS_LAD_MSB:`TOS_LAD_LSB];

  ////////////////////////////////////////////////////////////////////////
  // Address decode for writes
  assign wr_in_tieoff  = wr_i && (addr_i == `TOS_ADDR_IN_TIEOFF);
  assign wr_bias_force = wr_i && (addr_i == `TOS_ADDR_BIAS_FORCE);
  assign wr_amute_stat = wr_i && (addr_i == `TOS_ADDR_AMUTE_STAT);

  ////////////////////////////////////////////////////////////////////////
  // Per-input tie-off switch selection
  tos_switch_mux #(
    .N (`TOS_NIN)
  ) u_in_mux (
    .override_en_i (input_override_enable),
    .force_i       (in_force_bits),
    .auto_i        (auto_in_tieoff_i),
    .closed_o      (in_tieoff_closed_next)
  );

  ////////////////////////////////////////////////////////////////////////
  // Level-control readouts from left and right detectors
  tos_max_sel #(
    .W (`TOS_DW)
  ) u_p2p_sel (
    .left_en_i   (alc_left_en_i),
    .right_en_i  (alc_right_en_i),
    .left_val_i  (p2p_left_i),
    .right_val_i (p2p_right_i),
    .val_o       (peak_to_peak_value)
  );

  tos_max_sel #(
    .W (`TOS_DW)
  ) u_peak_sel (
    .left_en_i   (alc_left_en_i),
    .right_en_i  (alc_right_en_i),
    .left_val_i  (peak_left_i),
    .right_val_i (peak_right_i),
    .val_o       (peak_detector_value)
  );

  ////////////////////////////////////////////////////////////////////////
  // Noise gate comparison source and state
  assign gate_compare_value = gate_source_select_i ?
    peak_to_peak_value : peak_detector_value;

  always @* begin
    noise_gate_next = (gate_compare_value < gate_threshold_i);
  end

  ////////////////////////////////////////////////////////////////////////
  // Status word for the mixed register
  assign status_word = {
    {(`TOS_DW-`TOS_AMUTE_SEL_BIT-1){1'b0}},
    automute_point_select_reg,
    1'b0,
    speaker_supply_high_reg,
    noise_gate_reg
  };

  ////////////////////////////////////////////////////////////////////////
  // Next values of writable registers; read-only fields never written
  always @* begin
    input_tieoff_manual_ctrl_next   = input_tieoff_manual_ctrl_reg;
    bias_trim_and_buffer_force_next = bias_trim_and_buffer_force_reg;
    automute_point_select_next      = automute_point_select_reg;
    if (wr_in_tieoff) begin
      input_tieoff_manual_ctrl_next = wdata_i;
    end
    if (wr_bias_force) begin
      bias_trim_and_buffer_force_next = wdata_i & `TOS_BIAS_WMASK;
    end
    if (wr_amute_stat) begin
      automute_point_select_next = wdata_i[`TOS_AMUTE_SEL_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read multiplexer; unmapped addresses return zero
  always @* begin
    case (addr_i)
      `TOS_ADDR_IN_TIEOFF: begin
        rdata_next = input_tieoff_manual_ctrl_reg;
      end
      `TOS_ADDR_BIAS_FORCE: begin
        rdata_next = bias_trim_and_buffer_force_reg;
      end
      `TOS_ADDR_P2P: begin
        rdata_next = peak_to_peak_value;
      end
      `TOS_ADDR_PEAK: begin
        rdata_next = peak_detector_value;
      end
      `TOS_ADDR_AMUTE_STAT: begin
        rdata_next = status_word;
      end
      default: begin
        rdata_next = `TOS_ZERO9;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Control register storage
  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      input_tieoff_manual_ctrl_reg   <= `TOS_IN_TIEOFF_RST;
      bias_trim_and_buffer_force_reg <= `TOS_BIAS_FORCE_RST;
      automute_point_select_reg      <= `TOS_AMUTE_SEL_RST;
    end else begin
      input_tieoff_manual_ctrl_reg   <= input_tieoff_manual_ctrl_next;
      bias_trim_and_buffer_force_reg <= bias_trim_and_buffer_force_next;
      automute_point_select_reg      <= automute_point_select_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Live status sampling
  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      speaker_supply_high_reg <= 1'b0;
      noise_gate_reg          <= 1'b0;
    end else begin
      speaker_supply_high_reg <= speaker_supply_high_i;
      noise_gate_reg          <= noise_gate_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registered read data and valid
  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_o  <= `TOS_RDATA_RST;
      rvalid_o <= 1'b0;
    end else begin
      rvalid_o <= rd_i;
      if (rd_i) begin
        rdata_o <= rdata_next;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Switch controls to the analog side
  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      in_tieoff_closed_o     <= {`TOS_NIN{1'b0}};
      buf_bypass_closed_o    <= 1'b0;
      buf_ground_closed_o    <= 1'b0;
      ladder_ground_closed_o <= {`TOS_NLAD{1'b0}};
    end else begin
      in_tieoff_closed_o <= in_tieoff_closed_next;
      // Forced closed only while the buffer is disabled
      buf_bypass_closed_o <= (force_in_buffer_bypass &&
                              in_buffer_disabled_i) ||
                             auto_buf_bypass_i;
      buf_ground_closed_o <= (force_in_buffer_ground &&
                              in_buffer_disabled_i) ||
                             auto_buf_ground_i;
      ladder_ground_closed_o <= force_ladder_ground |
                                pm_ladder_ground_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Bias trim controls and automute point
  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      half_bias_o             <= 1'b0;
      bias_up_o               <= 1'b0;
      bias_dn_o               <= 1'b0;
      automute_point_select_o <= `TOS_AMUTE_SEL_RST;
    end else begin
      half_bias_o             <= half_bias_select;
      bias_up_o               <= bias_increase_step;
      bias_dn_o               <= bias_decrease_step;
      automute_point_select_o <= automute_point_select_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Noise gate flag and gain hold to the level-control logic
  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      noise_gate_flag_o <= 1'b0;
      gain_hold_o       <= 1'b0;
    end else begin
      noise_gate_flag_o <= noise_gate_next;
      gain_hold_o       <= noise_gate_next;
    end
  end

endmodule // tos_regs

// >>> verif/tos_regs_assertions.sv
// Purpose: Port-level checks of the tie-off and status register bank.
// Assumes: Shadow copies follow every write to the writable words.
// Notes:   Bound to tos_regs from the testbench top file.
`timescale 1ns/1ps

module tos_regs_assertions (
  // Clock, reset and control port
  input wire       clock_i, nrst_i, wr_i, rd_i, rvalid_o,
  input wire [6:0] addr_i,
  input wire [8:0] wdata_i, rdata_o, gate_threshold_i,
  // Detector inputs and automatic controls
  input wire [8:0] p2p_left_i, p2p_right_i, peak_left_i, peak_right_i,
  input wire       alc_left_en_i, alc_right_en_i, gate_source_select_i,
  input wire [7:0] auto_in_tieoff_i, in_tieoff_closed_o,
  input wire       auto_buf_bypass_i, auto_buf_ground_i,
  input wire       in_buffer_disabled_i,
  input wire [2:0] pm_ladder_ground_i, ladder_ground_closed_o,
  // Switch, bias and flag outputs
  input wire       buf_bypass_closed_o, buf_ground_closed_o, half_bias_o,
  input wire       bias_up_o, bias_dn_o, automute_point_select_o,
  input wire       noise_gate_flag_o, gain_hold_o
);
  reg  [8:0] tie_reg;
  reg  [8:0] bias_reg;
  reg        amute_reg;
  reg        up_reg;
  // Readout choice: both under control gives the larger value
  wire       both = alc_left_en_i & alc_right_en_i;
  wire       ronly = alc_right_en_i & ~alc_left_en_i;
  wire [8:0] p2p_sel = both ? (p2p_left_i > p2p_right_i ? p2p_left_i :
                       p2p_right_i) : ronly ? p2p_right_i : p2p_left_i;
  wire [8:0] pk_sel = both ? (peak_left_i > peak_right_i ? peak_left_i :
                      peak_right_i) : ronly ? peak_right_i : peak_left_i;
  wire       gate_lt = (gate_source_select_i ? p2p_sel : pk_sel)
                       < gate_threshold_i;
  wire [7:0] exp_tie = tie_reg[8] ? tie_reg[7:0] : auto_in_tieoff_i;
  wire       exp_bp = (bias_reg[4] & in_buffer_disabled_i) |
                      auto_buf_bypass_i;
  wire       exp_gd = (bias_reg[3] & in_buffer_disabled_i) |
                      auto_buf_ground_i;
  wire [2:0] exp_lad = bias_reg[2:0] | pm_ladder_ground_i;
  wire [2:0] exp_bias = {bias_reg[8], bias_reg[6:5]};

  ////////////////////////////////////////////////////////////////////////
  // Shadow copies of the writable words
  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tie_reg <= 9'h000;
      bias_reg <= 9'h000;
      amute_reg <= 1'b0;
      up_reg <= 1'b0;
    end else begin
      up_reg <= 1'b1;
      if (wr_i && addr_i == 7'h4a) tie_reg <= wdata_i;
      if (wr_i && addr_i == 7'h4b) bias_reg <= wdata_i & 9'h17f;
      if (wr_i && addr_i == 7'h4e) amute_reg <= wdata_i[3];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  sequence s_rd_p2p;
    rd_i && addr_i == 7'h4c;
  endsequence
  sequence s_rd_peak;
    rd_i && addr_i == 7'h4d;
  endsequence

  chk_tieoff_select: assert property (
    up_reg |-> in_tieoff_closed_o == $past(exp_tie))
    else $error("tie-off switch output wrong");
  chk_bypass_force: assert property (
    up_reg |-> buf_bypass_closed_o == $past(exp_bp))
    else $error("buffer bypass switch wrong");
  chk_ground_force: assert property (
    up_reg |-> buf_ground_closed_o == $past(exp_gd))
    else $error("buffer ground switch wrong");
  chk_ladder_force: assert property (
    up_reg |-> ladder_ground_closed_o == $past(exp_lad))
    else $error("ladder ground switch wrong");
  chk_bias_controls: assert property (
    up_reg |-> {half_bias_o, bias_up_o, bias_dn_o} == $past(exp_bias))
    else $error("bias control outputs wrong");
  chk_automute_sel: assert property (
    up_reg |-> automute_point_select_o == $past(amute_reg))
    else $error("automute point select wrong");
  chk_gate_flag: assert property (
    up_reg |-> noise_gate_flag_o == $past(gate_lt) &&
    gain_hold_o == noise_gate_flag_o)
    else $error("noise gate flag wrong");
  chk_read_pulse: assert property (
    up_reg |-> rvalid_o == $past(rd_i))
    else $error("read valid pulse wrong");
  chk_p2p_readout: assert property (
    s_rd_p2p |=> rdata_o == $past(p2p_sel))
    else $error("peak-to-peak readout wrong");
  chk_peak_readout: assert property (
    s_rd_peak |=> rdata_o == $past(pk_sel))
    else $error("peak readout wrong");
  chk_rdata_hold: assert property (
    !rd_i |=> $stable(rdata_o))
    else $error("read data changed without read");
endmodule // tos_regs_assertions

// >>> verif/test_tos_regs.sv
// Purpose: Self-checking bench for the tie-off and status register bank.
// Assumes: Inputs change on the falling clock edge.
// Notes:   Each scenario is a task that judges its own results.
`timescale 1ns/1ps

module test_tos_regs;
  reg        clock_i, nrst_i, wr_i, rd_i, alc_left_en_i, alc_right_en_i;
  reg        gate_source_select_i, speaker_supply_high_i;
  reg        auto_buf_bypass_i, auto_buf_ground_i, in_buffer_disabled_i;
  reg  [6:0] addr_i;
  reg  [8:0] wdata_i, p2p_left_i, p2p_right_i, peak_left_i, peak_right_i;
  reg  [8:0] gate_threshold_i;
  reg  [7:0] auto_in_tieoff_i;
  reg  [2:0] pm_ladder_ground_i;
  wire [8:0] rdata_o;
  wire [7:0] in_tieoff_closed_o;
  wire [2:0] ladder_ground_closed_o;
  wire       rvalid_o, buf_bypass_closed_o, buf_ground_closed_o;
  wire       half_bias_o, bias_up_o, bias_dn_o, automute_point_select_o;
  wire       noise_gate_flag_o, gain_hold_o;
  // Narrow outputs widened on purpose for the compare task
  wire [8:0] bias_ctl = {6'h00, half_bias_o, bias_up_o, bias_dn_o};
  wire [8:0] lad_sw = {6'h00, ladder_ground_closed_o};
  wire [8:0] buf_sw = {7'h00, buf_bypass_closed_o, buf_ground_closed_o};
  wire [8:0] gate_fl = {7'h00, noise_gate_flag_o, gain_hold_o};
  integer    n_mismatch, n_tests, i;

  tos_regs i_tos_regs (.*);

  // Free-running core clock
  initial begin
    clock_i = 1'b0;
    forever #2.5 clock_i = ~clock_i;
  end

  ////////////////////////////////////////////////////////////////////////
  task check_val(input [8:0] got, input [8:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task wr(input [6:0] a, input [8:0] d);
    begin
      @(negedge clock_i);
      addr_i = a;
      wdata_i = d;
      wr_i = 1'b1;
      @(negedge clock_i);
      wr_i = 1'b0;
    end
  endtask
  task rd(input [6:0] a, input [8:0] exp);
    begin
      @(negedge clock_i);
      addr_i = a;
      rd_i = 1'b1;
      @(negedge clock_i);
      rd_i = 1'b0;
      check_val({8'h00, rvalid_o}, 9'h001);
      check_val(rdata_o, exp);
    end
  endtask
  task stop_test;
    begin
      $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  task t_tieoff;
    begin
      rd(7'h4a, 9'h000);
      wr(7'h4a, 9'h0a5);
      @(negedge clock_i);
      check_val({1'b0, in_tieoff_closed_o}, 9'h03c);
      for (i = 0; i < 8; i = i + 1) begin
        wr(7'h4a, 9'h100 | (9'h001 << i));
        @(negedge clock_i);
        check_val({1'b0, in_tieoff_closed_o}, 9'h001 << i);
      end
      rd(7'h4a, 9'h180);
      wr(7'h4a, 9'h000);
      auto_in_tieoff_i = 8'hc3;
      @(negedge clock_i);
      check_val({1'b0, in_tieoff_closed_o}, 9'h0c3);
      $display("test tieoff done");
    end
  endtask
  task t_bias;
    begin
      rd(7'h4b, 9'h000);
      wr(7'h4b, 9'h1d0);
      @(negedge clock_i);
      check_val(bias_ctl, 9'h006);
      check_val(lad_sw, 9'h005);
      check_val(buf_sw, 9'h000);
      in_buffer_disabled_i = 1'b1;
      @(negedge clock_i);
      check_val(buf_sw, 9'h002);
      rd(7'h4b, 9'h150);
      wr(7'h4b, 9'h02a);
      @(negedge clock_i);
      check_val(bias_ctl, 9'h001);
      check_val(lad_sw, 9'h007);
      check_val(buf_sw, 9'h001);
      in_buffer_disabled_i = 1'b0;
      auto_buf_bypass_i = 1'b1;
      @(negedge clock_i);
      check_val(buf_sw, 9'h002);
      wr(7'h4b, 9'h000);
      pm_ladder_ground_i = 3'h2;
      auto_buf_ground_i = 1'b1;
      @(negedge clock_i);
      check_val(lad_sw, 9'h002);
      check_val(buf_sw, 9'h003);
      $display("test bias done");
    end
  endtask
  task t_readout;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        {alc_left_en_i, alc_right_en_i} = i[1:0];
        rd(7'h4c, (i == 1) ? 9'h0f3 : 9'h120);
        rd(7'h4d, (i[0]) ? 9'h1e0 : 9'h011);
      end
      wr(7'h4c, 9'h1ff);
      wr(7'h10, 9'h1ff);
      rd(7'h4c, 9'h120);
      rd(7'h10, 9'h000);
      p2p_left_i = 9'h001;
      rd(7'h4c, 9'h0f3);
      $display("test readout done");
    end
  endtask
  task t_status;
    begin
      wr(7'h4e, 9'h1ff);
      @(negedge clock_i);
      check_val({8'h00, automute_point_select_o}, 9'h001);
      rd(7'h4e, 9'h008);
      speaker_supply_high_i = 1'b1;
      gate_threshold_i = 9'h100;
      @(negedge clock_i);
      check_val(gate_fl, 9'h000);
      gate_source_select_i = 1'b1;
      @(negedge clock_i);
      check_val(gate_fl, 9'h003);
      rd(7'h4e, 9'h00b);
      wr(7'h4e, 9'h000);
      @(negedge clock_i);
      check_val({8'h00, automute_point_select_o}, 9'h000);
      $display("test status done");
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    n_mismatch = 0;
    n_tests = 0;
    {nrst_i, wr_i, rd_i, alc_left_en_i, alc_right_en_i, addr_i, wdata_i,
     gate_source_select_i, speaker_supply_high_i, auto_buf_bypass_i,
     auto_buf_ground_i, in_buffer_disabled_i, gate_threshold_i} = '0;
    {p2p_left_i, p2p_right_i} = {9'h120, 9'h0f3};
    {peak_left_i, peak_right_i} = {9'h011, 9'h1e0};
    auto_in_tieoff_i = 8'h3c;
    pm_ladder_ground_i = 3'h5;
    repeat (10) @(negedge clock_i);
    nrst_i = 1'b1;
    t_tieoff;
    t_bias;
    t_readout;
    t_status;
    stop_test;
  end

  // Watchdog against a hang
  initial begin
    #25000;
    n_mismatch = n_mismatch + 1;
    $display("[FAIL] %0t watchdog expired", $time);
    stop_test;
  end
endmodule // test_tos_regs

bind tos_regs tos_regs_assertions i_tos_regs_assertions (.*);
